// file: pkg/cvrp_pkg.sv
`default_nettype none
package cvrp_pkg;
   // Dot rate and character cell
   localparam int unsigned SYS_CLK_MHZ = 250;
   localparam int unsigned CHAR_TIME_NS = 349;
   localparam int unsigned CHAR_TIME_CYC = (CHAR_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] DOTS_PER_CHAR = 4'h9;
   localparam logic [3:0] DOT_LAST = 4'h8;
   localparam logic [3:0] DOT_LOAD_ARM = 4'h7;
   // Horizontal timing in character times
   localparam logic [6:0] H_ACTIVE = 7'h50;
   localparam logic [6:0] H_TOTAL = 7'h73;
   localparam logic [6:0] H_LAST = 7'h72;
   localparam logic [6:0] HS_START = 7'h3F;
   localparam logic [6:0] HS_END = 7'h46;
   // Vertical timing in scan lines
   localparam logic [3:0] SCANS_PER_ROW = 4'hF;
   localparam logic [3:0] SCAN_LAST = 4'hE;
   localparam logic [4:0] ROWS = 5'h1A;
   localparam logic [8:0] V_ACTIVE = 9'h186;
   localparam logic [8:0] VB_LEN_60 = 9'h019;
   localparam logic [8:0] VB_LEN_50 = 9'h06C;
   localparam logic [8:0] VS_DLY_60 = 9'h000;
   localparam logic [8:0] VS_DLY_50 = 9'h026;
   localparam logic [8:0] VS_W_60 = 9'h013;
   localparam logic [8:0] VS_W_50 = 9'h040;
   localparam logic [8:0] V_TOTAL_60 = 9'h19F;
   localparam logic [8:0] V_TOTAL_50 = 9'h1F2;
   // Row fetch schedule
   localparam logic [3:0] FETCH_SCAN_A = 4'h6;
   localparam logic [3:0] FETCH_SCAN_B = 4'hE;
   localparam logic [3:0] NMI_SCAN_A = 4'h4;
   localparam logic [3:0] NMI_SCAN_B = 4'hC;
   localparam logic [6:0] FETCH_LEN = 7'h50;
   // Host register load decode and status port
   localparam logic [1:0] LOAD_DECODE = 2'h2;
   localparam logic [1:0] SEL_ROW_START = 2'h2;
   localparam logic [15:0] STATUS_ADDR = 16'h0000;
   localparam int unsigned VBL_BIT = 0;
   // Character codes and dot selector
   localparam logic [7:0] CTRL_CODE_LIMIT = 8'h20;
   localparam logic [2:0] DOT_SEL_NORMAL = 3'h5;
   localparam logic [2:0] DOT_SEL_HALF = 3'h4;
   localparam logic BLANK_DOT = 1'b1;
   // Character ROM size modes
   typedef enum logic [1:0] {CVRP_ROM_2K, CVRP_ROM_4K, CVRP_ROM_8K, CVRP_ROM_RSVD} cvrp_rom_e;
endpackage
`default_nettype wire

// file: hw/cvrp_dot_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module cvrp_dot_shifter
   import cvrp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Load and pattern
   input wire logic dot_shifter_load_n,
   input wire logic [6:0] pattern_n,
   // Dot stream, low means lit
   output logic dot_n
);
   logic [7:0] shift_r;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         shift_r <= 8'hFF;
      else if (!dot_shifter_load_n)
         shift_r <= {pattern_n, BLANK_DOT};
      else
         shift_r <= {BLANK_DOT, shift_r[7:1]};
   end

   // Leading blank, seven pattern dots, then a trailing blank from the fill
   assign dot_n = shift_r[0];

   property p_shift_load;
      @(posedge sys_clk) disable iff (!arst_n)
      !dot_shifter_load_n |=> shift_r == {$past(pattern_n), BLANK_DOT};
   endproperty
   a_shift_load: assert property (p_shift_load) else $error("shifter load wrong");

   property p_shift_fill;
      @(posedge sys_clk) disable iff (!arst_n)
      dot_shifter_load_n |=> shift_r[7] == BLANK_DOT;
   endproperty
   a_shift_fill: assert property (p_shift_fill) else $error("shifter fill not blank");
endmodule
`default_nettype wire

// file: hw/cvrp_top.sv
// Overview of operation
// - Vertical blank lasts 25 lines at 60 Hz, 108 lines at 50 Hz.
// - Vertical sync starts 0 lines (60 Hz) or 38 lines (50 Hz) into blank.
// - Vertical sync lasts 19 lines at 60 Hz, 64 lines at 50 Hz.
// - Frame is 415 lines at 60 Hz, 498 lines at 50 Hz.
// - Each fetch reads 80 consecutive bytes from row start into a line buffer.
// - Interrupt to host two scan lines before the fetch bus request.
// - Host write with top address bits 1,0 is a register load.
// - Two low data bits pick the register; value 2 picks row start.
// - Next two address bits are kept as upper fetch address bits.
// - Vertical blank is readable on a status port.
// - Codes from the line buffer are re-registered on the character clock.
// - Standard set: seven code bits, top bit zero, codes below 32 control.
// - ROM address is code plus scan count; small ROM uses top bit as select.
// - Larger ROMs: top bit picks set; largest adds enhancement bit.
// - Eight dot times between ROM address and pattern load.
// - Shifter loads on the dot clock edge while load strobe is low.
// - Seven active-low dots load behind a blank leading stage.
// - ROM top output is held for the character as half-shift enable.
// - Normal scan uses dot source select code 101.
// - Shifter advances eight dots, filling with blanks.
// - Each character emits nine dots, first and last blank.
// - Scan line is 80 active plus 35 blank character times.
// - Horizontal sync starts 16 before last active character, lasts 7.
// - 26 rows of 15 scan lines give 390 active lines.
// - Fetch bus request on scan lines 6 and 14 of each row.
`timescale 1ns/1ps
`default_nettype none
module cvrp_top
   import cvrp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Static configuration pins
   input wire logic rate_50hz_sel,
   input wire logic [1:0] rom_mode,
   // Host register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Host handshake
   output logic host_nmi_n,
   output logic fetch_bus_request_n,
   // Display memory read port, data one cycle after the strobe
   output logic [13:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   // Character pattern ROM
   output logic [12:0] rom_addr,
   output logic rom_cs_n,
   input wire logic [7:0] rom_data,
   // Video out
   output logic char_clock,
   output logic dot_shifter_load_n,
   output logic [2:0] dot_src_sel,
   output logic half_shift_en,
   output logic video_dot_n,
   output logic hsync,
   output logic vsync,
   output logic vertical_blank_flag
);
   // Pin synchronisers, three stages, accepted when the last two agree
   logic [2:0] cfg_s1_r, cfg_s2_r, cfg_s3_r, cfg_r;
   logic rate_50_r;
   cvrp_rom_e rom_mode_r;

   // Timing
   logic [3:0] dot_cnt_r;
   logic char_en;
   logic [6:0] hcnt_r;
   logic line_end;
   logic [8:0] line_r;
   logic [3:0] scan_r;
   logic [4:0] row_r;
   logic [8:0] v_total, vb_len, vs_dly, vs_w;
   logic frame_end;

   // Fetch
   logic [11:0] row_start_r;
   logic [1:0] fetch_upper_r;
   logic fetch_line;
   logic fetch_enh;
   logic [6:0] fetch_idx_r;
   logic fill_r;
   logic fill_enh_r;
   logic [6:0] fill_idx_r;
   logic [7:0] char_buf [0:79];
   logic [7:0] enh_buf [0:79];

   // Character pipeline
   logic [7:0] code_r;
   logic enh_hi_r;
   logic act_d1_r, act_d2_r;
   logic dot_raw_n;
   logic reg_load;

   // Config synchroniser
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_s1_r <= 3'h0;
         cfg_s2_r <= 3'h0;
         cfg_s3_r <= 3'h0;
         cfg_r <= 3'h0;
      end
      else
      begin
         cfg_s1_r <= {rate_50hz_sel, rom_mode};
         cfg_s2_r <= cfg_s1_r;
         cfg_s3_r <= cfg_s2_r;
         if (cfg_s2_r == cfg_s3_r)
            cfg_r <= cfg_s3_r;
      end
   end

   // Rate is taken only as a frame wraps so a frame never mixes timing sets
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rate_50_r <= 1'b0;
         rom_mode_r <= CVRP_ROM_2K;
      end
      else
      begin
         if (frame_end)
            rate_50_r <= cfg_r[2];
         rom_mode_r <= cvrp_rom_e'(cfg_r[1:0]);
      end
   end

   assign v_total = rate_50_r ? V_TOTAL_50 : V_TOTAL_60;
   assign vb_len = rate_50_r ? VB_LEN_50 : VB_LEN_60;
   assign vs_dly = rate_50_r ? VS_DLY_50 : VS_DLY_60;
   assign vs_w = rate_50_r ? VS_W_50 : VS_W_60;

   // Divide by nine for the character clock
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         dot_cnt_r <= 4'h0;
      else if (dot_cnt_r == DOT_LAST)
         dot_cnt_r <= 4'h0;
      else
         dot_cnt_r <= dot_cnt_r + 4'h1;
   end

   assign char_en = (dot_cnt_r == DOT_LAST);
   assign line_end = char_en && (hcnt_r == H_LAST);
   assign frame_end = line_end && (line_r == v_total - 9'h001);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         hcnt_r <= 7'h0;
      else if (line_end)
         hcnt_r <= 7'h0;
      else if (char_en)
         hcnt_r <= hcnt_r + 7'h1;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         line_r <= 9'h0;
         scan_r <= 4'h0;
         row_r <= 5'h0;
      end
      else if (frame_end)
      begin
         line_r <= 9'h0;
         scan_r <= 4'h0;
         row_r <= 5'h0;
      end
      else if (line_end)
      begin
         line_r <= line_r + 9'h001;
         if (scan_r == SCAN_LAST)
         begin
            scan_r <= 4'h0;
            if (row_r != ROWS)
               row_r <= row_r + 5'h01;
         end
         else
            scan_r <= scan_r + 4'h1;
      end
   end

   // Sync and blank outputs, registered one cycle behind the counters
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hsync <= 1'b0;
         vsync <= 1'b0;
         vertical_blank_flag <= 1'b0;
      end
      else
      begin
         hsync <= (hcnt_r >= HS_START) && (hcnt_r < HS_END);
         vertical_blank_flag <= (line_r >= V_ACTIVE) && (line_r < V_ACTIVE + vb_len);
         vsync <= (line_r >= V_ACTIVE + vs_dly) && (line_r < V_ACTIVE + vs_dly + vs_w);
      end
   end

   // Host register load through a write to a ROM-decoded address
   assign reg_load = reg_wr && (reg_addr[15:14] == LOAD_DECODE) && (reg_wdata[1:0] == SEL_ROW_START);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         row_start_r <= 12'h000;
         fetch_upper_r <= 2'h0;
      end
      else if (reg_load)
      begin
         row_start_r <= reg_addr[11:0];
         fetch_upper_r <= reg_addr[13:12];
      end
   end

   // Status read; other addresses read zero
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd && reg_addr == STATUS_ADDR)
      begin
         reg_rdata <= 8'h00;
         reg_rdata[VBL_BIT] <= vertical_blank_flag;
      end
      else
         reg_rdata <= 8'h00;
   end

   // Fetch and interrupt schedule; the row-25 fetch preloads the next frame's first row
   assign fetch_line = (row_r < ROWS) && ((scan_r == FETCH_SCAN_A) || (scan_r == FETCH_SCAN_B));
   assign fetch_enh = (scan_r == FETCH_SCAN_A);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         host_nmi_n <= 1'b1;
         fetch_bus_request_n <= 1'b1;
      end
      else
      begin
         host_nmi_n <= !((row_r < ROWS) && ((scan_r == NMI_SCAN_A) || (scan_r == NMI_SCAN_B)));
         fetch_bus_request_n <= !fetch_line;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fetch_idx_r <= 7'h0;
         mem_rd <= 1'b0;
         mem_addr <= 14'h0000;
      end
      else
      begin
         mem_rd <= 1'b0;
         if (line_end)
            fetch_idx_r <= 7'h0;
         else if (char_en && fetch_line && !fetch_bus_request_n && fetch_idx_r < FETCH_LEN)
         begin
            mem_rd <= 1'b1;
            mem_addr <= {fetch_upper_r, row_start_r + {5'h00, fetch_idx_r}};
            fetch_idx_r <= fetch_idx_r + 7'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fill_r <= 1'b0;
         fill_enh_r <= 1'b0;
         fill_idx_r <= 7'h0;
      end
      else
      begin
         fill_r <= mem_rd;
         if (mem_rd)
         begin
            fill_enh_r <= fetch_enh;
            fill_idx_r <= fetch_idx_r - 7'h1;
         end
      end
   end

   // Buffer reads for a column precede the refill of that column by two cycles
   always_ff @(posedge sys_clk)
   begin
      if (fill_r && !fill_enh_r)
         char_buf[fill_idx_r] <= mem_rdata;
      if (fill_r && fill_enh_r)
         enh_buf[fill_idx_r] <= mem_rdata;
   end

   // Character latch and ROM address
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         code_r <= 8'h00;
         enh_hi_r <= 1'b0;
         act_d1_r <= 1'b0;
         act_d2_r <= 1'b0;
      end
      else if (char_en)
      begin
         act_d1_r <= (hcnt_r < H_ACTIVE) && (line_r < V_ACTIVE);
         act_d2_r <= act_d1_r;
         if (hcnt_r < H_ACTIVE)
         begin
            code_r <= char_buf[hcnt_r];
            enh_hi_r <= enh_buf[hcnt_r][6];
         end
         else
            code_r <= 8'h00;
      end
   end

   // Codes below CTRL_CODE_LIMIT are control characters but still address the ROM
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rom_addr <= 13'h0000;
         rom_cs_n <= 1'b1;
      end
      else
      begin
         rom_addr <= {enh_hi_r, code_r[7], code_r[6:0], scan_r};
         unique case (rom_mode_r)
            CVRP_ROM_2K: rom_cs_n <= code_r[7];
            CVRP_ROM_4K: rom_cs_n <= enh_hi_r;
            CVRP_ROM_8K: rom_cs_n <= 1'b0;
            default: rom_cs_n <= 1'b1;
         endcase
      end
   end

   // Pattern loads eight dot times after its address to cover ROM access
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dot_shifter_load_n <= 1'b1;
         char_clock <= 1'b0;
      end
      else
      begin
         dot_shifter_load_n <= !(dot_cnt_r == DOT_LOAD_ARM);
         char_clock <= (dot_cnt_r < DOTS_PER_CHAR[3:1]);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         half_shift_en <= 1'b0;
         dot_src_sel <= DOT_SEL_NORMAL;
      end
      else if (char_en)
      begin
         half_shift_en <= rom_data[7];
         dot_src_sel <= rom_data[7] ? DOT_SEL_HALF : DOT_SEL_NORMAL;
      end
   end

   cvrp_dot_shifter u_shifter (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .dot_shifter_load_n(dot_shifter_load_n),
      .pattern_n(rom_data[6:0]),
      .dot_n(dot_raw_n)
   );

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         video_dot_n <= BLANK_DOT;
      else
         video_dot_n <= act_d2_r ? dot_raw_n : BLANK_DOT;
   end

   // Checks
   sequence s_load_cmd;
      reg_load;
   endsequence

   property p_reg_load;
      @(posedge sys_clk) disable iff (!arst_n)
      s_load_cmd |=> row_start_r == $past(reg_addr[11:0]) && fetch_upper_r == $past(reg_addr[13:12]);
   endproperty
   a_reg_load: assert property (p_reg_load) else $error("register load not captured");

   property p_no_load;
      @(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr[15:14] != LOAD_DECODE |=> $stable(row_start_r);
   endproperty
   a_no_load: assert property (p_no_load) else $error("row start changed without decode");

   property p_frame_wrap;
      @(posedge sys_clk) disable iff (!arst_n)
      line_end && line_r == (rate_50_r ? V_TOTAL_50 : V_TOTAL_60) - 9'h001 |=> line_r == 9'h0;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame length wrong");

   property p_vertical_blank_flag;
      @(posedge sys_clk) disable iff (!arst_n)
      line_r == V_ACTIVE |=> vertical_blank_flag;
   endproperty
   a_vertical_blank_flag: assert property (p_vertical_blank_flag) else $error("vertical blank missing");

   property p_vsync60;
      @(posedge sys_clk) disable iff (!arst_n)
      !rate_50_r && line_r == V_ACTIVE + VS_W_60 |=> !vsync;
   endproperty
   a_vsync60: assert property (p_vsync60) else $error("vertical sync too long");

   property p_hsync;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(hsync) |-> $past(hcnt_r) == HS_START;
   endproperty
   a_hsync: assert property (p_hsync) else $error("horizontal sync misplaced");

   property p_nmi_lead;
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(host_nmi_n) |-> $past(scan_r) == NMI_SCAN_A || $past(scan_r) == NMI_SCAN_B;
   endproperty
   a_nmi_lead: assert property (p_nmi_lead) else $error("interrupt not two lines ahead");

   property p_busreq;
      @(posedge sys_clk) disable iff (!arst_n)
      mem_rd |-> !fetch_bus_request_n ##1 fill_r;
   endproperty
   a_busreq: assert property (p_busreq) else $error("fetch outside bus request");

   property p_half;
      @(posedge sys_clk) disable iff (!arst_n)
      char_en |=> half_shift_en == $past(rom_data[7]) && dot_src_sel[2] && dot_src_sel[0] != $past(rom_data[7]);
   endproperty
   a_half: assert property (p_half) else $error("half-shift enable not held");

   property p_half_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      !char_en |=> $stable(half_shift_en) && $stable(dot_src_sel);
   endproperty
   a_half_hold: assert property (p_half_hold) else $error("half-shift enable changed mid character");

   sequence s_load_edge;
      !dot_shifter_load_n ##1 dot_shifter_load_n [*8];
   endsequence

   property p_char_period;
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(dot_shifter_load_n) |-> s_load_edge ##1 !dot_shifter_load_n;
   endproperty
   a_char_period: assert property (p_char_period) else $error("load not every nine dots");

   property p_status;
      @(posedge sys_clk) disable iff (!arst_n)
      reg_rd && reg_addr == STATUS_ADDR |=> reg_rdata[VBL_BIT] == $past(vertical_blank_flag);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");
endmodule
`default_nettype wire

// file: verification/cvrp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cvrp_mem_model
   import cvrp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Display memory
   input wire logic [13:0] mem_addr,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata,
   // Pattern ROM
   input wire logic rom_cs_n,
   input wire logic [7:0] rom_val,
   output logic [7:0] rom_data
);
   // Enhancement block sits 80 above the characters; bit 10 tells them apart
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         mem_rdata <= 8'hA5;
      else if (mem_rd)
         mem_rdata <= mem_addr[10] ? 8'h40 : 8'hC1;
      else
         mem_rdata <= ~mem_rdata;
   end
   // Deselected ROM shows the inverse so stale data cannot pass
   assign rom_data = rom_cs_n ? ~rom_val : rom_val;
endmodule
`default_nettype wire

// file: verification/cvrp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cvrp_top_tb;
   import cvrp_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic rate_50hz_sel = 1'b0;
   logic [1:0] rom_mode = 2'h2;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] rom_val = 8'h31;
   logic [7:0] reg_rdata, mem_rdata, rom_data;
   logic host_nmi_n, fetch_bus_request_n, mem_rd, rom_cs_n, char_clock, dot_shifter_load_n;
   logic half_shift_en, video_dot_n, hsync, vsync, vertical_blank_flag;
   logic [13:0] mem_addr;
   logic [12:0] rom_addr;
   logic [2:0] dot_src_sel;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int t_req = 0;

   cvrp_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .rate_50hz_sel(rate_50hz_sel), .rom_mode(rom_mode),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .host_nmi_n(host_nmi_n), .fetch_bus_request_n(fetch_bus_request_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .rom_addr(rom_addr), .rom_cs_n(rom_cs_n), .rom_data(rom_data),
      .char_clock(char_clock), .dot_shifter_load_n(dot_shifter_load_n), .dot_src_sel(dot_src_sel),
      .half_shift_en(half_shift_en), .video_dot_n(video_dot_n), .hsync(hsync), .vsync(vsync),
      .vertical_blank_flag(vertical_blank_flag));
   cvrp_mem_model model (.sys_clk(sys_clk), .arst_n(arst_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .rom_cs_n(rom_cs_n), .rom_val(rom_val), .rom_data(rom_data));

   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      cyc <= cyc + 1;

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Bounded wait so a stuck output cannot hang the run
   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 20000)
      begin
         step(1);
         n++;
      end
      if (n == 20000)
         chk("wait", 16'h0001, 16'h0000);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic t_reset;
      // Flops only take their reset values at the first clock edge
      step(1);
      chk("nmi_n", 16'h1, host_nmi_n);
      chk("busreq_n", 16'h1, fetch_bus_request_n);
      chk("load_n", 16'h1, dot_shifter_load_n);
      chk("cs_n", 16'h1, rom_cs_n);
      chk("dot_n", 16'h1, video_dot_n);
      chk("src", 16'h5, dot_src_sel);
      chk("syncs", 16'h0, {hsync, vsync, vertical_blank_flag, reg_rdata});
      step(2);
      arst_n <= 1'b1;
      $display("test reset done");
   endtask
   // Host forces the top bits to 1,0 and writes 02H; other patterns are ignored
   task automatic t_regs;
      logic [7:0] d;
      wr(16'h9400, 8'h02);
      wr(16'h5123, 8'h02);
      wr(16'hD123, 8'h02);
      wr(16'hA123, 8'h01);
      rd(16'h0000, d);
      chk("status", 16'h0, d);
      rd(16'h0004, d);
      chk("other_rd", 16'h0, d);
      $display("test regs done");
   endtask
   task automatic t_fetch(input logic [13:0] base, input logic first);
      int t0, t1, n;
      wait_for(host_nmi_n, 1'b0);
      t0 = cyc;
      wait_for(host_nmi_n, 1'b1);
      t1 = cyc;
      chk("nmi_len", 16'd1035, t1 - t0);
      wait_for(fetch_bus_request_n, 1'b0);
      chk("nmi_lead", 16'd2070, cyc - t0);
      if (!first)
         chk("req_gap", 16'd8280, cyc - t_req);
      t_req = cyc;
      n = 0;
      while (fetch_bus_request_n === 1'b0 && n < 200)
      begin
         if (mem_rd === 1'b1)
         begin
            chk("mem_addr", base + 14'(n), mem_addr);
            n++;
         end
         step(1);
      end
      chk("bytes", 16'd80, n);
      $display("test fetch done");
   endtask
   task automatic t_timing;
      int t0, n;
      wait_for(hsync, 1'b1);
      t0 = cyc;
      chk("blank_dot", 16'h1, video_dot_n);
      wait_for(hsync, 1'b0);
      chk("hs_width", 16'd63, cyc - t0);
      wait_for(hsync, 1'b1);
      chk("line", 16'd1035, cyc - t0);
      wait_for(dot_shifter_load_n, 1'b0);
      t0 = cyc;
      n = 0;
      repeat (9)
      begin
         step(1);
         n += char_clock;
      end
      chk("cclk_hi", 16'd4, n);
      wait_for(dot_shifter_load_n, 1'b0);
      chk("load_per", 16'd9, cyc - t0);
      $display("test timing done");
   endtask
   task automatic t_dots;
      logic [8:0] g, h;
      logic ok;
      logic [3:0] cs_exp;
      cs_exp = 4'b1011;
      wait_for(hsync, 1'b0);
      step(450);
      chk("rom_addr", 16'h1C10, rom_addr);
      chk("cs_8k", 16'h0, rom_cs_n);
      chk("src", 16'h5, dot_src_sel);
      chk("half", 16'h0, half_shift_en);
      for (int i = 0; i < 18; i++)
      begin
         if (i < 9)
            g[i] = video_dot_n;
         else
            h[i - 9] = video_dot_n;
         step(1);
      end
      ok = 1'b0;
      for (int r = 0; r < 9; r++)
         // Pattern is not a palindrome, so a reversed dot order cannot pass
         if (g === ((9'b101100011 << r) | (9'b101100011 >> (9 - r))))
            ok = 1'b1;
      chk("dots", 16'h1, ok);
      chk("repeat", g, h);
      rom_val <= 8'hD5;
      step(20);
      chk("half", 16'h1, half_shift_en);
      chk("src_half", 16'h4, dot_src_sel);
      for (int m = 0; m < 4; m++)
      begin
         rom_mode <= 2'(m);
         step(20);
         chk("cs_mode", cs_exp[m], rom_cs_n);
      end
      $display("test dots done");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge sys_clk);
      error_cnt++;
      results();
   end
   initial
   begin
      t_reset();
      step(4);
      t_regs();
      t_timing();
      t_fetch(14'h1400, 1'b1);
      wr(16'h93B0, 8'h02);
      t_fetch(14'h13B0, 1'b0);
      t_dots();
      results();
   end
endmodule
`default_nettype wire
